// >>> src/sal_bank.sv
// Shunt alert limit bank: six limit registers and the per-channel limit comparators.
// Assumes the two-wire register interface logic upstream presents decoded single-cycle
// read and write strobes on mclk_i, and that shunt results arrive as same-clock strobes.
`timescale 1ns/1ns
`default_nettype none
`include "sal_params.svh"
module sal_bank (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register access from the serial interface
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire sal_pkg::sal_addr_t reg_addr_i,
  input wire sal_pkg::sal_word_t reg_wdata_i,
  output sal_pkg::sal_word_t reg_rdata_o,
  output logic reg_rvalid_o,
  // Shunt results
  input wire logic [`SAL_CH_N-1:0] conv_valid_i,
  input wire logic [`SAL_CH_N*`SAL_DATA_W-1:0] conv_data_i,
  input wire logic [`SAL_CH_N-1:0] avg_valid_i,
  input wire logic [`SAL_CH_N*`SAL_DATA_W-1:0] avg_data_i,
  // Flag read strobe and comparison outcomes
  input wire logic flag_read_i,
  output logic [`SAL_CH_N-1:0] fast_overcurrent_flags_o,
  output logic critical_alert_o,
  output logic [`SAL_CH_N-1:0] sustained_exceed_o
);
  import sal_pkg::*;

  localparam int NREG = 2 * `SAL_CH_N;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode: offsets map to store index, fast limit even, sustained odd
  function automatic logic [2:0] sal_index(input sal_addr_t a);
    sal_addr_t d;
    d = a - `SAL_ADDR_FIRST;
    return d[2:0]; // [RULE3] [RULE4]
  endfunction : sal_index

  function automatic logic sal_mapped(input sal_addr_t a);
    return (a >= `SAL_ADDR_FIRST) && (a <= `SAL_ADDR_LAST);
  endfunction : sal_mapped

  // Only the 13-bit field takes part; low reserved bits are dropped
  function automatic logic sal_exceeds(input sal_word_t meas, input sal_word_t lim);
    sal_field_t m;
    sal_field_t l;
    m = sal_field_t'(meas[`SAL_FIELD_MSB:`SAL_FIELD_LSB]); // [RULE9]
    l = sal_field_t'(lim[`SAL_FIELD_MSB:`SAL_FIELD_LSB]); // [RULE6]
    return m > l; // [RULE8] [RULE11]
  endfunction : sal_exceeds

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    sal_rd_state_t rd_state;
    logic rd_mapped;
    logic [`SAL_CH_N-1:0] flags;
    logic [`SAL_CH_N-1:0] sust;
  } sal_bank_state_t;

  sal_bank_state_t st;
  sal_bank_state_t next_st;
  logic [NREG*`SAL_DATA_W-1:0] words;
  sal_word_t store_rdata;
  logic wr_hit;

  assign wr_hit = reg_wr_i && sal_mapped(reg_addr_i);

  sal_limit_store #(
    .DEPTH(NREG)
  ) u_store (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_hit),
    .wr_idx_i(sal_index(reg_addr_i)),
    .wr_data_i(reg_wdata_i),
    .rd_idx_i(sal_index(reg_addr_i)),
    .rd_data_o(store_rdata),
    .words_o(words)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    case (st.rd_state)
      SAL_IDLE: begin
        if (reg_rd_i) begin
          next_st.rd_state = SAL_READ;
          next_st.rd_mapped = sal_mapped(reg_addr_i);
        end
      end
      SAL_READ: begin
        // Back-to-back reads stay here so each strobe gets its answer
        next_st.rd_state = reg_rd_i ? SAL_READ : SAL_IDLE;
        next_st.rd_mapped = sal_mapped(reg_addr_i);
      end
      default: begin
        next_st.rd_state = SAL_IDLE;
      end
    endcase
    // A flag read clears, but a new exceed in the same cycle wins
    if (flag_read_i) begin
      next_st.flags = '0; // [RULE10]
    end
    for (int c = 0; c < `SAL_CH_N; c++) begin
      if (conv_valid_i[c] &&
          sal_exceeds(conv_data_i[c*`SAL_DATA_W +: `SAL_DATA_W],
                      words[(2*c)*`SAL_DATA_W +: `SAL_DATA_W])) begin
        next_st.flags[c] = 1'b1; // [RULE1] [RULE10]
      end
      // Sustained outcome follows the latest average only
      if (avg_valid_i[c]) begin
        next_st.sust[c] = sal_exceeds(avg_data_i[c*`SAL_DATA_W +: `SAL_DATA_W],
                                      words[(2*c+1)*`SAL_DATA_W +: `SAL_DATA_W]); // [RULE2]
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st.rd_state <= SAL_IDLE;
      st.rd_mapped <= 1'b0;
      st.flags <= '0;
      st.sust <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rvalid_o = (st.rd_state == SAL_READ);
  assign reg_rdata_o = (reg_rvalid_o && st.rd_mapped) ? store_rdata : `SAL_UNMAPPED_READ;
  assign fast_overcurrent_flags_o = st.flags;
  assign critical_alert_o = |st.flags; // [RULE10]
  assign sustained_exceed_o = st.sust;
endmodule : sal_bank
`default_nettype wire

// >>> src/sal_limit_store.sv
// Six-word limit store with registered read data.
// Assumes a single clock and synchronous reset; index 0 is the first limit register.
`timescale 1ns/1ns
`default_nettype none
`include "sal_params.svh"
module sal_limit_store #(
  parameter int DEPTH = 6
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [2:0] wr_idx_i,
  input wire logic [`SAL_DATA_W-1:0] wr_data_i,
  // Read port
  input wire logic [2:0] rd_idx_i,
  output logic [`SAL_DATA_W-1:0] rd_data_o,
  // All words, for the comparators
  output logic [DEPTH*`SAL_DATA_W-1:0] words_o
);
  // Three index bits cannot reach beyond eight words
  if (DEPTH < 1 || DEPTH > 8) begin : g_depth_check
    $error("sal_limit_store: DEPTH out of range");
  end

  typedef struct packed {
    logic [DEPTH-1:0][`SAL_DATA_W-1:0] mem;
    logic [`SAL_DATA_W-1:0] rd;
  } sal_store_state_t;

  sal_store_state_t st;
  sal_store_state_t next_st;

  always_comb begin
    next_st = st;
    if (wr_en_i && int'(wr_idx_i) < DEPTH) begin
      next_st.mem[wr_idx_i] = wr_data_i; // [RULE5] [RULE6]
    end
    next_st.rd = (int'(rd_idx_i) < DEPTH) ? st.mem[rd_idx_i] : `SAL_UNMAPPED_READ;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st.mem <= {DEPTH{`SAL_LIMIT_RESET}}; // [RULE7]
      st.rd <= `SAL_UNMAPPED_READ;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data_o = st.rd;
  assign words_o = st.mem;
endmodule : sal_limit_store
`default_nettype wire

// >>> src/sal_params.svh
// Constants for the shunt alert limit bank: register offsets, field layout, reset values.
// Assumes inclusion by bare name from the package and the design modules.
//
// Function
// [RULE1] Each channel's fast limit is checked against every single shunt conversion.
// [RULE2] Each channel's sustained limit is checked against the averaged shunt value only.
// [RULE3] Fast limits for channels 1, 2, 3 sit at 07h, 09h, 0Bh.
// [RULE4] Sustained limits for channels 1, 2, 3 sit at 08h, 0Ah, 0Ch.
// [RULE5] Each limit holds a 13-bit read/write value in bits 15 to 3.
// [RULE6] Bits 2 to 0 are writable, reset to zero, and ignored when comparing.
// [RULE7] All six limits read 7FF8h after reset.
// [RULE8] Shunt values and limits are signed two's complement; comparison is signed.
// [RULE9] Limits share the shunt result's bit weight, full scale 7FF8.
// [RULE10] Fast limit exceeded sets that channel's critical flag; reading the flags clears them.
// [RULE11] Exceeded means measurement strictly greater than the limit field.
`ifndef SAL_PARAMS_SVH
`define SAL_PARAMS_SVH
`define SAL_ADDR_W 8
`define SAL_DATA_W 16
`define SAL_CH_N 3
`define SAL_FIELD_W 13
`define SAL_FIELD_LSB 3
`define SAL_FIELD_MSB 15
`define SAL_ADDR_CH1_FAST 8'h07
`define SAL_ADDR_CH1_SUST 8'h08
`define SAL_ADDR_CH2_FAST 8'h09
`define SAL_ADDR_CH2_SUST 8'h0a
`define SAL_ADDR_CH3_FAST 8'h0b
`define SAL_ADDR_CH3_SUST 8'h0c
`define SAL_ADDR_FIRST 8'h07
`define SAL_ADDR_LAST 8'h0c
`define SAL_LIMIT_RESET 16'h7ff8
`define SAL_UNMAPPED_READ 16'h0000
`endif

// >>> src/sal_pkg.sv
// Types shared by the shunt alert limit bank.
// Assumes sal_params.svh is on the include path.
`include "sal_params.svh"
package sal_pkg;
  typedef logic [`SAL_ADDR_W-1:0] sal_addr_t;
  typedef logic [`SAL_DATA_W-1:0] sal_word_t;
  typedef logic signed [`SAL_FIELD_W-1:0] sal_field_t;
  typedef enum logic [1:0] {
    SAL_IDLE = 2'h0,
    SAL_READ = 2'h1
  } sal_rd_state_t;
endpackage : sal_pkg

// >>> tb/sal_bank_monitor.sv
// Port checker for the limit bank.
// Assumes one clock and a synchronous reset; bound from tb.
`timescale 1ns/1ns
`default_nettype none
module sal_bank_monitor (
  input wire logic mclk_i, rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, flag_read_i, critical_alert_o,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i, reg_rdata_o,
  input wire logic [2:0] conv_valid_i, avg_valid_i, fast_overcurrent_flags_o, sustained_exceed_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr7; reg_wr_i && reg_addr_i == 8'h07; endsequence
  sequence s_rd7; !reg_wr_i ##1 reg_rd_i && !reg_wr_i && reg_addr_i == 8'h07; endsequence
  chk_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  chk_rv_pulse: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("answer without read");
  chk_write_readback: assert property (s_wr7 ##1 s_rd7 |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("written word not read back");
  chk_unmapped_zero: assert property (reg_rd_i && (reg_addr_i < 8'h07 || reg_addr_i > 8'h0c)
    |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
  chk_alert_or: assert property (critical_alert_o == (|fast_overcurrent_flags_o))
    else $error("alert differs from flags");
  chk_flag_clear: assert property (flag_read_i && conv_valid_i == 3'h0 |=> fast_overcurrent_flags_o == 3'h0)
    else $error("flags not cleared");
  chk_flag_stick: assert property (!flag_read_i |=>
    (fast_overcurrent_flags_o & $past(fast_overcurrent_flags_o)) == $past(fast_overcurrent_flags_o))
    else $error("flag dropped");
  chk_flag_cause: assert property (conv_valid_i == 3'h0 |=>
    (fast_overcurrent_flags_o & ~$past(fast_overcurrent_flags_o)) == 3'h0)
    else $error("flag without conversion");
  chk_sust_hold: assert property (avg_valid_i == 3'h0 |=> $stable(sustained_exceed_o))
    else $error("sustained result moved");
endmodule : sal_bank_monitor
`default_nettype wire

// >>> tb/sal_host_model.sv
// Host side of the register path: one-cycle strobes.
// Assumes the answer comes one cycle after the strobe edge.
`timescale 1ns/1ns
`default_nettype none
module sal_host_model (
  input wire logic mclk_i,
  input wire logic rvalid_i,
  input wire logic [15:0] rdata_i,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic [7:0] addr_o = 8'h00,
  output logic [15:0] wdata_o = 16'h0000
);
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    // Released lines show garbage, not the last value
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge mclk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge mclk_i);
    d = rdata_i;
    v = rvalid_i;
  endtask : rd
endmodule : sal_host_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the limit bank.
// Assumes the host model drives the register strobes.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic mclk = 1'b0, rst = 1'b1, wr, rd, rvalid, fr = 1'b0, alert, v;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, d, lim;
  logic [2:0] cv = 3'h0, av = 3'h0, flags, sust;
  logic [47:0] cd = 48'h0, ad = 48'h0;
  int bad_count = 0, n_compared = 0, cyc = 0;
  always #5 mclk = ~mclk;
  sal_host_model host (.mclk_i(mclk), .rvalid_i(rvalid), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata));
  sal_bank DUT (.mclk_i(mclk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .conv_valid_i(cv), .conv_data_i(cd),
    .avg_valid_i(av), .avg_data_i(ad), .flag_read_i(fr), .fast_overcurrent_flags_o(flags),
    .critical_alert_o(alert), .sustained_exceed_o(sust));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  task automatic feed(input logic avg, input int c, input logic [15:0] x);
    @(posedge mclk);
    cd[16*c+:16] <= x;
    ad[16*c+:16] <= x;
    if (avg) av <= 3'h1 << c;
    else cv <= 3'h1 << c;
    @(posedge mclk);
    av <= 3'h0;
    cv <= 3'h0;
    @(posedge mclk);
  endtask : feed
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_words;
    for (int a = 6; a <= 13; a++) begin
      host.rd(8'(a), d, v);
      chk("rvalid", 16'h1, {15'h0, v});
      chk("reset word", (a >= 7 && a <= 12) ? 16'h7ff8 : 16'h0000, d);
    end
  endtask : t_reset_words
  task automatic t_readback;
    for (int a = 7; a <= 13; a++) host.wr(8'(a), {8'(a), 8'h05});
    for (int a = 7; a <= 13; a++) begin
      host.rd(8'(a), d, v);
      chk("word", (a <= 12) ? {8'(a), 8'h05} : 16'h0000, d);
    end
    // Write then read at once, sign and reserved bits set; then restore the limit
    host.wr(8'h07, 16'h8003);
    host.rd(8'h07, d, v);
    chk("signed word", 16'h8003, d);
    host.wr(8'h07, 16'h0705);
  endtask : t_readback
  task automatic t_fast;
    for (int c = 0; c < 3; c++) begin
      lim = {8'(7 + 2 * c), 8'h05};
      feed(1'b0, c, lim | 16'h0007);
      chk("equal not exceeded", 16'h0, {13'h0, flags});
      feed(1'b0, c, 16'h8000);
      chk("negative", 16'h0, {13'h0, flags});
      feed(1'b0, c, lim + 16'h0008);
      chk("fast flag", 16'h1 << c, {13'h0, flags});
      chk("alert", 16'h1, {15'h0, alert});
      @(posedge mclk);
      fr <= 1'b1;
      @(posedge mclk);
      fr <= 1'b0;
      @(posedge mclk);
      chk("cleared", 16'h0, {12'h0, alert, flags});
    end
  endtask : t_fast
  task automatic t_sust;
    for (int c = 0; c < 3; c++) begin
      lim = {8'(8 + 2 * c), 8'h05};
      feed(1'b1, c, lim + 16'h0008);
      chk("sustained", 16'h1 << c, {13'h0, sust});
      chk("no fast flag", 16'h0, {13'h0, flags});
      feed(1'b1, c, lim | 16'h0007);
      chk("sustained equal", 16'h0, {13'h0, sust});
    end
  endtask : t_sust
  task automatic t_reset_mid;
    feed(1'b0, 0, 16'h7ff8);
    feed(1'b1, 0, 16'h7ff8);
    chk("pre-reset flag", 16'h1, {13'h0, flags});
    chk("pre-reset sustained", 16'h1, {13'h0, sust});
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("reset outputs", 16'h0, {9'h0, alert, flags, sust});
    rst <= 1'b0;
    host.rd(8'h07, d, v);
    chk("reset fast limit", 16'h7ff8, d);
    host.rd(8'h0c, d, v);
    chk("reset sustained limit", 16'h7ff8, d);
  endtask : t_reset_mid
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_reset_words();
    t_readback();
    t_fast();
    t_sust();
    t_reset_mid();
    results();
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      results();
    end
  end
endmodule : tb
bind sal_bank sal_bank_monitor mon (.mclk_i(mclk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rvalid_o(reg_rvalid_o), .flag_read_i(flag_read_i), .critical_alert_o(critical_alert_o),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .conv_valid_i(conv_valid_i),
  .avg_valid_i(avg_valid_i), .fast_overcurrent_flags_o(fast_overcurrent_flags_o),
  .sustained_exceed_o(sustained_exceed_o));
`default_nettype wire
